/* File: rtl/usb_ep_pkg.sv */
// shared constants, register map and enumerations for the endpoint mode engine
package usb_ep_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  // mode register fields
  localparam int MODE_LSB = 0;
  localparam int PID_SETUP_BIT = 4;
  localparam int PID_IN_BIT = 5;
  localparam int PID_OUT_BIT = 6;
  // count register fields
  localparam int CNT_LSB = 0;
  localparam int CNT_VALID_BIT = 6;
  localparam int CNT_TOG_BIT = 7;
  // status register fields
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  // reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] CNT_RST = 4'h0;
  // endpoint modes
  localparam logic [3:0] M_DISABLE = 4'h0;
  localparam logic [3:0] M_NAK_IO = 4'h1;
  localparam logic [3:0] M_ISO_OUT = 4'h5;
  localparam logic [3:0] M_ISO_IN = 4'h7;
  localparam logic [3:0] M_NAK_OUT = 4'h8;
  localparam logic [3:0] M_ACK_OUT = 4'h9;
  localparam logic [3:0] M_NAK_OUT_SIN = 4'ha;
  localparam logic [3:0] M_ACK_OUT_SIN = 4'hb;
  localparam logic [3:0] M_NAK_IN = 4'hc;
  localparam logic [3:0] M_ACK_IN = 4'hd;
  localparam logic [3:0] M_NAK_IN_SOUT = 4'he;
  localparam logic [3:0] M_ACK_IN_SOUT = 4'hf;
  // received packet limits, byte counts include the two crc bytes
  localparam logic [4:0] RX_MAX_CNT = 5'h0a;
  localparam logic [4:0] RX_ZLP_CNT = 5'h02;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} tok_e;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_e;
  typedef enum logic [2:0] {ACT_IGNORE, ACT_NAK, ACT_STALL, ACT_ACK, ACT_CHECK,
    ACT_ALWAYS, ACT_TX0, ACT_TXCNT} act_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP_DATA, ST_OUT_DATA, ST_IN_WAIT} st_e;
endpackage

/* File: rtl/usb_endpoint_mode_engine.sv */
// endpoint mode engine: token responses, mode advance, pid status, write lock, axi4-lite regs
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module usb_endpoint_mode_engine
  import usb_ep_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // token and packet events from the serial interface engine
  input wire logic tok_valid,
  input wire tok_e tok_type,
  input wire logic data_start,
  input wire logic data_done,
  input wire logic [4:0] data_cnt,
  input wire logic data_err,
  input wire logic data_toggle_bit,
  input wire logic host_ack,
  input wire logic xact_abort,
  input wire logic buf_corrupt,
  // responses to the serial interface engine
  output logic hs_valid,
  output hs_e hs_code,
  output logic tx_start,
  output logic [3:0] tx_len,
  output logic ep_irq
);
  st_e st_q, st_d;
  act_e act_q, act_d;
  logic [3:0] mode_q;
  logic [3:0] cnt_q;
  logic tog_q, dval_q;
  logic pid_setup_q, pid_in_q, pid_out_q;
  logic lock_q;

  // combinational decisions
  logic rx_ok, chk_ok;
  logic hs_go, tx_go, irq_go, len0;
  hs_e hs_kind;
  logic set_setup, set_in, set_out;
  logic hw_mode_we, cnt_we, lock_set;
  logic [3:0] hw_mode;

  function automatic logic setup_ok(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'ha, 4'hb, 4'he, 4'hf: setup_ok = 1'b1;
      default: setup_ok = 1'b0;
    endcase
  endfunction

  function automatic act_e in_act(input logic [3:0] m);
    case (m)
      4'h1, 4'hc, 4'he: in_act = ACT_NAK;
      4'h2, 4'h3: in_act = ACT_STALL;
      4'h6, 4'ha, 4'hb: in_act = ACT_TX0;
      4'h7, 4'hd, 4'hf: in_act = ACT_TXCNT;
      default: in_act = ACT_IGNORE;
    endcase
  endfunction

  function automatic act_e out_act(input logic [3:0] m);
    case (m)
      4'h1, 4'h8, 4'ha: out_act = ACT_NAK;
      4'h3, 4'h6: out_act = ACT_STALL;
      4'h2, 4'he, 4'hf: out_act = ACT_CHECK;
      4'h5: out_act = ACT_ALWAYS;
      4'h9, 4'hb: out_act = ACT_ACK;
      default: out_act = ACT_IGNORE;
    endcase
  endfunction

  assign rx_ok = (data_cnt <= RX_MAX_CNT) && !data_err;
  assign chk_ok = rx_ok && (data_cnt == RX_ZLP_CNT) && data_toggle_bit;

  always_comb
  begin
    st_d = st_q;
    act_d = act_q;
    hs_go = 1'b0;
    hs_kind = HS_ACK;
    tx_go = 1'b0;
    len0 = 1'b0;
    irq_go = buf_corrupt;
    set_setup = 1'b0;
    set_in = 1'b0;
    set_out = 1'b0;
    hw_mode_we = 1'b0;
    hw_mode = mode_q;
    cnt_we = 1'b0;
    lock_set = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (tok_valid)
        begin
          case (tok_type)
            TOK_SETUP:
            begin
              // disabled and non-control modes drop the token silently
              if (mode_q != M_DISABLE && setup_ok(mode_q))
                st_d = ST_SETUP_DATA;
            end
            TOK_OUT:
            begin
              act_d = out_act(mode_q);
              if (act_d != ACT_IGNORE)
                st_d = ST_OUT_DATA;
            end
            TOK_IN:
            begin
              act_d = in_act(mode_q);
              case (act_d)
                ACT_NAK, ACT_STALL:
                begin
                  hs_go = 1'b1;
                  hs_kind = (act_d == ACT_NAK) ? HS_NAK : HS_STALL;
                  set_in = 1'b1;
                  irq_go = 1'b1;
                end
                ACT_TX0, ACT_TXCNT:
                begin
                  tx_go = 1'b1;
                  len0 = (act_d == ACT_TX0);
                  // isochronous in expects no handshake back
                  if (mode_q == M_ISO_IN)
                  begin
                    set_in = 1'b1;
                    irq_go = 1'b1;
                  end
                  else
                    st_d = ST_IN_WAIT;
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end
      end
      ST_SETUP_DATA:
      begin
        set_setup = data_start;
        if (xact_abort)
          st_d = ST_IDLE;
        else if (data_done)
        begin
          st_d = ST_IDLE;
          cnt_we = 1'b1;
          irq_go = 1'b1;
          if (rx_ok)
          begin
            hs_go = 1'b1;
            hw_mode_we = 1'b1;
            hw_mode = M_NAK_IO;
            lock_set = 1'b1;
          end
        end
      end
      ST_OUT_DATA:
      begin
        if (xact_abort)
          st_d = ST_IDLE;
        else if (data_done)
        begin
          st_d = ST_IDLE;
          // bad packets to nak, stall or check modes get no answer at all
          if (rx_ok || act_q == ACT_ACK || act_q == ACT_ALWAYS)
          begin
            set_out = 1'b1;
            irq_go = 1'b1;
          end
          case (act_q)
            ACT_NAK:
            begin
              hs_go = rx_ok;
              hs_kind = HS_NAK;
            end
            ACT_STALL:
            begin
              hs_go = rx_ok;
              hs_kind = HS_STALL;
            end
            ACT_ALWAYS: cnt_we = 1'b1;
            ACT_ACK:
            begin
              cnt_we = 1'b1;
              if (rx_ok)
              begin
                hs_go = 1'b1;
                lock_set = 1'b1;
                hw_mode_we = 1'b1;
                hw_mode = (mode_q == M_ACK_OUT) ? M_NAK_OUT : M_NAK_OUT_SIN;
              end
            end
            ACT_CHECK:
            begin
              hs_go = rx_ok;
              hs_kind = chk_ok ? HS_ACK : HS_STALL;
              lock_set = chk_ok;
            end
            default: ;
          endcase
        end
      end
      ST_IN_WAIT:
      begin
        if (host_ack)
        begin
          st_d = ST_IDLE;
          set_in = 1'b1;
          irq_go = 1'b1;
          lock_set = 1'b1;
          if (mode_q == M_ACK_IN || mode_q == M_ACK_IN_SOUT)
          begin
            hw_mode_we = 1'b1;
            hw_mode = (mode_q == M_ACK_IN) ? M_NAK_IN : M_NAK_IN_SOUT;
          end
        end
        else if (xact_abort)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_IDLE;
      act_q <= ACT_IGNORE;
    end
    else
    begin
      st_q <= st_d;
      act_q <= act_d;
    end
  end

  // response strobes to the serial interface engine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hs_valid <= 1'b0;
      hs_code <= HS_ACK;
      tx_start <= 1'b0;
      tx_len <= 4'h0;
      ep_irq <= 1'b0;
    end
    else
    begin
      hs_valid <= hs_go;
      hs_code <= hs_kind;
      tx_start <= tx_go;
      tx_len <= len0 ? 4'h0 : cnt_q;
      ep_irq <= irq_go;
    end
  end

  // axi write side: address and data taken together
  logic wr_go, rd_go, wr_ok, rd_sel_mode, rd_sel_cnt;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign wr_ok = (s_axi_awaddr == OFF_MODE) || (s_axi_awaddr == OFF_COUNT)
    || (s_axi_awaddr == OFF_STATUS);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_sel_mode = rd_go && (s_axi_araddr == OFF_MODE);
  assign rd_sel_cnt = rd_go && (s_axi_araddr == OFF_COUNT);

  logic cpu_mode_we, cpu_cnt_we;
  // a locked write still completes on the bus, it just changes nothing
  assign cpu_mode_we = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_MODE) && !lock_q;
  assign cpu_cnt_we = wr_go && s_axi_wstrb[0] && (s_axi_awaddr == OFF_COUNT) && !lock_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      case (s_axi_araddr)
        OFF_MODE:
        begin
          s_axi_rdata[MODE_LSB +: 4] <= mode_q;
          s_axi_rdata[PID_SETUP_BIT] <= pid_setup_q;
          s_axi_rdata[PID_IN_BIT] <= pid_in_q;
          s_axi_rdata[PID_OUT_BIT] <= pid_out_q;
        end
        OFF_COUNT:
        begin
          s_axi_rdata[CNT_LSB +: 4] <= cnt_q;
          s_axi_rdata[CNT_VALID_BIT] <= dval_q;
          s_axi_rdata[CNT_TOG_BIT] <= tog_q;
        end
        OFF_STATUS:
        begin
          s_axi_rdata[STAT_LOCK_BIT] <= lock_q;
          s_axi_rdata[STAT_BUSY_BIT] <= (st_q != ST_IDLE);
        end
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // mode: hardware advance wins over a cpu write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= MODE_RST;
    else if (hw_mode_we)
      mode_q <= hw_mode;
    else if (cpu_mode_we)
      mode_q <= s_axi_wdata[MODE_LSB +: 4];
  end

  // pid status: writing a one clears, a set in the same cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pid_setup_q <= 1'b0;
      pid_in_q <= 1'b0;
      pid_out_q <= 1'b0;
    end
    else
    begin
      pid_setup_q <= set_setup | (pid_setup_q & ~(cpu_mode_we & s_axi_wdata[PID_SETUP_BIT]));
      pid_in_q <= set_in | (pid_in_q & ~(cpu_mode_we & s_axi_wdata[PID_IN_BIT]));
      pid_out_q <= set_out | (pid_out_q & ~(cpu_mode_we & s_axi_wdata[PID_OUT_BIT]));
    end
  end

  // count, toggle and data-valid of the last received packet
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= CNT_RST;
      tog_q <= 1'b0;
      dval_q <= 1'b0;
    end
    else if (cnt_we)
    begin
      cnt_q <= (data_cnt > 5'h0f) ? 4'hf : data_cnt[3:0];
      tog_q <= data_toggle_bit;
      dval_q <= rx_ok;
    end
    else if (cpu_cnt_we)
    begin
      cnt_q <= s_axi_wdata[CNT_LSB +: 4];
      tog_q <= s_axi_wdata[CNT_TOG_BIT];
    end
  end

  // write lock; a read while a transaction is open does not release it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_q <= 1'b0;
    else if (lock_set)
      lock_q <= 1'b1;
    else if ((rd_sel_mode || rd_sel_cnt) && st_q == ST_IDLE)
      lock_q <= 1'b0;
  end

  property p_dis_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_IDLE && tok_valid && mode_q == M_DISABLE) |=> !hs_valid && !tx_start && !ep_irq;
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("disabled endpoint answered");

  property p_nak_in;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_IDLE && tok_valid && tok_type == TOK_IN && mode_q == M_NAK_IO)
      |=> hs_valid && hs_code == HS_NAK;
  endproperty
  a_nak_in: assert property (p_nak_in) else $error("mode 0001 did not nak in");

  property p_setup_force;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_SETUP_DATA && data_done && rx_ok && !xact_abort) |=> mode_q == M_NAK_IO;
  endproperty
  a_setup_force: assert property (p_setup_force) else $error("setup did not force nak mode");

  property p_setup_ack;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_SETUP_DATA && data_done && rx_ok && !xact_abort) |=> hs_valid && hs_code == HS_ACK;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("valid setup not acked");

  property p_long_silent;
    @(posedge aclk) disable iff (!aresetn)
    (st_q != ST_IDLE && data_done && data_cnt > RX_MAX_CNT) |=> !hs_valid;
  endproperty
  a_long_silent: assert property (p_long_silent) else $error("long packet answered");

  property p_ack_out_adv;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_OUT_DATA && act_q == ACT_ACK && data_done && rx_ok && !xact_abort
      && mode_q == M_ACK_OUT) |=> mode_q == M_NAK_OUT && lock_q;
  endproperty
  a_ack_out_adv: assert property (p_ack_out_adv) else $error("1001 did not become 1000");

  property p_in_adv;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_IN_WAIT && host_ack && mode_q == M_ACK_IN) |=> mode_q == M_NAK_IN && lock_q;
  endproperty
  a_in_adv: assert property (p_in_adv) else $error("1101 did not become 1100");

  property p_lock_blocks;
    @(posedge aclk) disable iff (!aresetn)
    (lock_q && !hw_mode_we) |=> $stable(mode_q);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked mode changed");

  property p_busy_keeps_lock;
    @(posedge aclk) disable iff (!aresetn)
    (lock_q && st_q != ST_IDLE) |=> lock_q;
  endproperty
  a_busy_keeps_lock: assert property (p_busy_keeps_lock) else $error("lock lifted early");

  property p_out_pid_late;
    @(posedge aclk) disable iff (!aresetn)
    (st_q == ST_IDLE && tok_valid && tok_type == TOK_OUT && !pid_out_q) |=> !pid_out_q;
  endproperty
  a_out_pid_late: assert property (p_out_pid_late) else $error("out pid set early");

  c_setup: cover property (@(posedge aclk) st_q == ST_SETUP_DATA ##1 hs_valid);
  c_in_ack: cover property (@(posedge aclk) st_q == ST_IN_WAIT && host_ack);
  c_unlock: cover property (@(posedge aclk) lock_q ##[1:20] !lock_q);
endmodule

/* File: verif/usb_host_model.sv */
// far-side model: tokens, data packets and host ack, plus response monitor
`timescale 1ns/1ps
module usb_host_model
  import usb_ep_pkg::*;
(
  // clock
  input wire logic aclk,
  // toward the engine
  output logic tok_valid,
  output tok_e tok_type,
  output logic data_start,
  output logic data_done,
  output logic [4:0] data_cnt,
  output logic data_err,
  output logic data_toggle_bit,
  output logic host_ack,
  output logic xact_abort,
  output logic buf_corrupt,
  // from the engine
  input wire logic hs_valid,
  input wire hs_e hs_code,
  input wire logic tx_start,
  input wire logic [3:0] tx_len,
  input wire logic ep_irq
);
  logic hs_got = 1'b0;
  logic tx_got = 1'b0;
  logic irq_got = 1'b0;
  hs_e hs_v;
  logic [3:0] tx_n;

  initial
  begin
    {tok_valid, data_start, data_done, data_err, host_ack, xact_abort, buf_corrupt} = '0;
    tok_type = TOK_SETUP;
    data_cnt = 5'h00;
    data_toggle_bit = 1'b0;
  end

  // outputs stand one cycle, so latch them for the bench
  always @(posedge aclk)
  begin
    // a token or corruption pulse opens a fresh observation; one driver only
    if (tok_valid || buf_corrupt)
    begin
      hs_got <= 1'b0;
      tx_got <= 1'b0;
      irq_got <= 1'b0;
    end
    if (hs_valid)
    begin
      hs_got <= 1'b1;
      hs_v <= hs_code;
    end
    if (tx_start)
    begin
      tx_got <= 1'b1;
      tx_n <= tx_len;
    end
    if (ep_irq)
      irq_got <= 1'b1;
  end

  task automatic xfer(input tok_e t, input logic [4:0] cnt, input logic tog, input logic err,
                      input logic ack);
    tok_valid <= 1'b1;
    tok_type <= t;
    @(posedge aclk);
    tok_valid <= 1'b0;
    if (t == TOK_IN)
    begin
      repeat (4) @(posedge aclk);
      // host acks only data it received; isochronous data is never acked
      host_ack <= tx_got & ack;
      @(posedge aclk);
      host_ack <= 1'b0;
    end
    else
    begin
      data_start <= 1'b1;
      @(posedge aclk);
      data_start <= 1'b0;
      data_done <= 1'b1;
      data_cnt <= cnt;
      data_err <= err;
      data_toggle_bit <= tog;
      @(posedge aclk);
      data_done <= 1'b0;
      // stale packet fields are scrambled so nothing leans on them
      data_cnt <= ~cnt;
      data_err <= ~err;
      data_toggle_bit <= ~tog;
    end
    repeat (4) @(posedge aclk);
  endtask

  task automatic corrupt();
    buf_corrupt <= 1'b1;
    @(posedge aclk);
    buf_corrupt <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // out token whose transaction the link drops before any data packet
  task automatic abort_out();
    tok_valid <= 1'b1;
    tok_type <= TOK_OUT;
    @(posedge aclk);
    tok_valid <= 1'b0;
    xact_abort <= 1'b1;
    @(posedge aclk);
    xact_abort <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
endmodule

/* File: verif/tb_usb_endpoint_mode_engine.sv */
// self-checking bench for the endpoint mode engine
`timescale 1ns/1ps
module tb_usb_endpoint_mode_engine
  import usb_ep_pkg::*;
;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, tx_len;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tok_valid, data_start, data_done, data_err, data_toggle_bit, host_ack, xact_abort;
  logic buf_corrupt, hs_valid, tx_start, ep_irq;
  tok_e tok_type;
  hs_e hs_code;
  logic [4:0] data_cnt;
  int failures, check_count, cycles;
  logic [31:0] rd;
  logic [1:0] rsp;

  usb_endpoint_mode_engine DUT (.*);
  usb_host_model serial_interface_engine (.*);

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      $display("[ERR] run length expected below 20000 seen 20000");
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // the read first lifts any lock left by the previous acked transaction
  task automatic setm(input logic [3:0] m);
    rd_reg(OFF_MODE);
    wr(OFF_COUNT, 32'h5);
    wr(OFF_MODE, {28'h7, m});
  endtask

  // 0 silent, 1 nak, 2 stall, 3 ack or data sent
  function automatic logic [1:0] seen();
    if (serial_interface_engine.hs_got === 1'b1)
      return (serial_interface_engine.hs_v === HS_NAK) ? 2'h1 : (serial_interface_engine.hs_v === HS_STALL) ? 2'h2 : 2'h3;
    return (serial_interface_engine.tx_got === 1'b1) ? 2'h3 : 2'h0;
  endfunction

  task automatic t_reset();
    rd_reg(OFF_MODE);
    chk("mode at reset", 32'h0, rd);
    rd_reg(OFF_COUNT);
    chk("count at reset", 32'h0, rd);
    rd_reg(OFF_STATUS);
    chk("status at reset", 32'h0, rd);
    wr(8'h0c, 32'h0);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    rd_reg(8'h0c);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_table(input tok_e t, input logic [31:0] tbl, input logic [4:0] cnt,
                         input logic tog);
    for (int m = 0; m < 16; m++)
    begin
      setm(4'(m));
      serial_interface_engine.xfer(t, cnt, tog, 1'b0, m != 7);
      chk($sformatf("reply in mode %0d", m), {30'h0, tbl[2*m +: 2]}, {30'h0, seen()});
      if (t == TOK_IN && tbl[2*m +: 2] == 2'h3)
        chk("tx length", (m == 6 || m == 10 || m == 11) ? 32'h0 : 32'h5, {28'h0, serial_interface_engine.tx_n});
    end
  endtask

  task automatic t_advance();
    logic [3:0] am [4] = '{4'h9, 4'hb, 4'hd, 4'hf};
    tok_e t;
    for (int i = 0; i < 4; i++)
    begin
      t = (i < 2) ? TOK_OUT : TOK_IN;
      setm(am[i]);
      serial_interface_engine.xfer(t, 5'h02, 1'b1, 1'b0, 1'b1);
      rd_reg(OFF_MODE);
      chk("mode after ack", {28'h0, am[i] - 4'h1}, rd & 32'hf);
      chk("pid after xact", 32'h1, {31'h0, rd[(i < 2) ? PID_OUT_BIT : PID_IN_BIT]});
      serial_interface_engine.xfer(t, 5'h02, 1'b1, 1'b0, 1'b1);
      chk("follow-on nak", 32'h1, {30'h0, seen()});
    end
  endtask

  task automatic t_lock();
    setm(4'h2);
    serial_interface_engine.xfer(TOK_SETUP, 5'h0a, 1'b0, 1'b0, 1'b1);
    chk("setup handshake", 32'h3, {30'h0, seen()});
    chk("setup irq", 32'h1, {31'h0, serial_interface_engine.irq_got});
    rd_reg(OFF_STATUS);
    chk("lock set", 32'h1, rd & 32'h1);
    wr(OFF_MODE, 32'h3);
    chk("locked write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    rd_reg(OFF_MODE);
    chk("mode locked", 32'h1, rd & 32'hf);
    chk("setup pid", 32'h1, {31'h0, rd[PID_SETUP_BIT]});
    rd_reg(OFF_STATUS);
    chk("lock lifted", 32'h0, rd & 32'h1);
    wr(OFF_MODE, 32'h3);
    rd_reg(OFF_MODE);
    chk("mode after unlock", 32'h3, rd & 32'hf);
    rd_reg(OFF_COUNT);
    chk("count after setup", 32'h4a, rd);
  endtask

  task automatic t_invalid();
    setm(4'h9);
    serial_interface_engine.abort_out();
    chk("aborted out", 32'h0, {30'h0, seen()});
    chk("aborted irq", 32'h0, {31'h0, serial_interface_engine.irq_got});
    serial_interface_engine.xfer(TOK_OUT, 5'h0b, 1'b1, 1'b0, 1'b1);
    chk("oversize out", 32'h0, {30'h0, seen()});
    serial_interface_engine.xfer(TOK_OUT, 5'h02, 1'b1, 1'b1, 1'b1);
    chk("errored out", 32'h0, {30'h0, seen()});
    rd_reg(OFF_MODE);
    chk("mode kept", 32'h9, rd & 32'hf);
    setm(4'h2);
    serial_interface_engine.xfer(TOK_OUT, 5'h02, 1'b0, 1'b0, 1'b1);
    chk("status toggle 0", 32'h2, {30'h0, seen()});
    serial_interface_engine.xfer(TOK_OUT, 5'h03, 1'b1, 1'b0, 1'b1);
    chk("status payload", 32'h2, {30'h0, seen()});
    serial_interface_engine.corrupt();
    chk("corrupt irq", 32'h1, {31'h0, serial_interface_engine.irq_got});
  endtask

  initial
  begin
    {failures, check_count, cycles} = '0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_table(TOK_IN, 32'hddf0f0a4, 5'h02, 1'b1);
    t_table(TOK_OUT, 32'hf0dd20b4, 5'h02, 1'b1);
    t_table(TOK_SETUP, 32'hf0f033fc, 5'h0a, 1'b0);
    t_advance();
    t_lock();
    t_invalid();
    give_verdict();
  end
endmodule
